/* File: sim/arcp_host_model.sv */
// Serial host model: frames command bytes and reads answers back.
// Assumes a pulled-up data line; the serial clock idles high between frames.
`timescale 1ns/1ps
module arcp_host_model (
  output logic      link_scl,
  output logic      link_frame,
  output logic      link_read,
  output logic      sda_in,
  input  wire logic sda_out,
  input  wire logic sda_oe
);
  logic host_low = 1'b0;
  initial begin
    link_scl = 1'b1;
    link_frame = 1'b0;
    link_read = 1'b0;
  end
  // Open drain: released line reads high
  assign sda_in = !host_low && (!sda_oe || sda_out);

  // Data changes just after a falling edge; the answer is taken at the rising edge
  task automatic tick(input logic d, input logic f, output logic s);
    #1 host_low = !d;
    link_frame = f;
    #2 link_scl = 1'b1;
    s = sda_in;
    #3 link_scl = 1'b0;
  endtask
  task automatic open_frame(input logic rd);
    logic s;
    link_read = rd;
    #3 link_scl = 1'b0;
    repeat (12) tick(1'b1, 1'b0, s);
  endtask
  task automatic close_frame;
    #1 link_frame = 1'b0;
    host_low = 1'b0;
    #2 link_scl = 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) tick(b[i], 1'b1, ack);
    tick(1'b1, 1'b1, ack);
  endtask
  task automatic write_frame(input logic [15:0] bytes, input int n, output logic [1:0] acks);
    acks = 2'b00;
    open_frame(1'b0);
    put_byte(bytes[15:8], acks[1]);
    if (n > 1) put_byte(bytes[7:0], acks[0]);
    close_frame();
  endtask
  task automatic read_frame(input int n, output logic [23:0] w);
    logic [7:0] b;
    logic       s;
    w = 24'hFFFFFF;
    open_frame(1'b1);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) tick(1'b1, 1'b1, b[i]);
      tick(1'b0, 1'b1, s);
      w = {w[15:0], b};
    end
    close_frame();
  endtask
endmodule

/* File: sim/arcp_top_asserts.sv */
// Pin-level checks on the converter command port.
// Assumes it is bound into arcp_top and sees only its ports.
`timescale 1ns/1ps
module arcp_top_asserts #(
  parameter int RESULT_W = 24
) (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                link_scl,
  input wire logic                link_frame,
  input wire logic                link_read,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe,
  input wire logic                conv_done,
  input wire logic [RESULT_W-1:0] conv_result,
  input wire logic [2:0]          input_pair_select,
  input wire logic                gain_x4,
  input wire logic [1:0]          rate_code,
  input wire logic                conversion_style,
  input wire logic                ext_ref_select,
  input wire logic                filter_restart,
  input wire logic                result_ready_n_out,
  input wire logic                result_ready_n_oe,
  input wire logic                result_ready_flag
);
  logic [7:0] setup;
  assign setup = {input_pair_select, gain_x4, rate_code, conversion_style, ext_ref_select};

  // Reset itself is the trigger here, so it cannot also disable the check
  a_reset_clear:
    assert property (@(posedge clock) sys_rst |=> setup == 8'h00 && !result_ready_flag)
    else $error("reset left setup or ready flag set");
  a_done_flag:
    assert property (@(posedge clock) disable iff (sys_rst) conv_done |=> result_ready_flag)
    else $error("new result did not set ready flag");
  a_pin_flag:
    assert property (@(posedge clock) disable iff (sys_rst) result_ready_n_oe == result_ready_flag && !result_ready_n_out)
    else $error("ready pin disagrees with ready flag");
  a_flag_cause:
    assert property (@(posedge clock) disable iff (sys_rst) $rose(result_ready_flag) |-> $past(conv_done))
    else $error("ready flag rose without a result");
  a_flag_fall:
    assert property (@(posedge clock) disable iff (sys_rst) $fell(result_ready_flag) |-> !$past(conv_done))
    else $error("ready flag fell on a new result");
  a_restart_pulse:
    assert property (@(posedge clock) disable iff (sys_rst) filter_restart |=> !filter_restart)
    else $error("filter restart longer than one cycle");
  a_setup_restart:
    assert property (@(posedge clock) disable iff (sys_rst)
      !$stable(setup) |-> (filter_restart || $past(filter_restart)) or ##1 filter_restart)
    else $error("setup changed without filter restart");
  a_addr_quiet:
    assert property (@(negedge link_scl) disable iff (sys_rst) !link_frame && !$past(link_frame) |-> !sda_oe)
    else $error("data line driven outside a frame");
  a_ack_single:
    assert property (@(negedge link_scl) disable iff (sys_rst) link_frame && !link_read && sda_oe |=> !sda_oe)
    else $error("write acknowledge held past one bit");

  c_restart: cover property (@(posedge clock) filter_restart);
  c_fetch: cover property (@(posedge clock) $fell(result_ready_flag));
  c_ack: cover property (@(negedge link_scl) sda_oe && !link_read);
endmodule

bind arcp_top arcp_top_asserts #(.RESULT_W(RESULT_W)) i_arcp_top_asserts (.clock, .sys_rst, .link_scl,
  .link_frame, .link_read, .sda_in, .sda_out, .sda_oe, .conv_done, .conv_result, .input_pair_select,
  .gain_x4, .rate_code, .conversion_style, .ext_ref_select, .filter_restart, .result_ready_n_out,
  .result_ready_n_oe, .result_ready_flag);

/* File: sim/arcp_top_bench.sv */
// Self-checking bench for the converter command port.
// Assumes the host model carries every link transfer.
`timescale 1ns/1ps
module arcp_top_bench;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        conv_done = 1'b0;
  logic [23:0] conv_result = 24'h000000;
  logic        link_scl, link_frame, link_read, sda_in, sda_out, sda_oe;
  logic [2:0]  input_pair_select;
  logic [1:0]  rate_code;
  logic        gain_x4, conversion_style, ext_ref_select, filter_restart;
  logic        result_ready_n_out, result_ready_n_oe, result_ready_flag;
  logic [7:0]  setup_o;
  logic [23:0] w;
  logic [1:0]  acks;
  int          failures = 0;
  int          tests_run = 0;
  int          restarts = 0;
  logic [7:0]  vals [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  logic [7:0]  others [4] = '{8'h02, 8'h06, 8'h08, 8'h50};

  assign setup_o = {input_pair_select, gain_x4, rate_code, conversion_style, ext_ref_select};
  always #5 clock = ~clock;
  // Counts restart pulses so a write of an unchanged value is still seen
  always @(posedge clock) if (filter_restart) restarts <= restarts + 1;

  arcp_top #(.RESULT_W(24)) i_arcp_top (.clock(clock), .sys_rst(sys_rst), .link_scl(link_scl),
    .link_frame(link_frame), .link_read(link_read), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_done(conv_done), .conv_result(conv_result), .input_pair_select(input_pair_select),
    .gain_x4(gain_x4), .rate_code(rate_code), .conversion_style(conversion_style),
    .ext_ref_select(ext_ref_select), .filter_restart(filter_restart), .result_ready_n_out(result_ready_n_out),
    .result_ready_n_oe(result_ready_n_oe), .result_ready_flag(result_ready_flag));
  arcp_host_model i_arcp_host_model (.link_scl(link_scl), .link_frame(link_frame), .link_read(link_read),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_read(input logic [7:0] cmd, input logic [7:0] exp);
    i_arcp_host_model.write_frame({cmd, 8'h00}, 1, acks);
    i_arcp_host_model.read_frame(2, w);
    // Second byte lies past the register, so the line stays released
    check("register", {8'hFF, exp, 8'hFF}, w);
  endtask
  task automatic fetch(input logic [23:0] exp);
    i_arcp_host_model.write_frame(16'h1A00, 1, acks);
    i_arcp_host_model.read_frame(3, w);
    check("result", exp, w);
  endtask
  task automatic convert(input logic [23:0] r);
    @(posedge clock);
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge clock);
    conv_done <= 1'b0;
    conv_result <= ~r;
  endtask
  task automatic apply_reset;
    // The link resets through a synchroniser, so it needs serial edges during reset
    sys_rst <= 1'b1;
    fork
      begin
        i_arcp_host_model.open_frame(1'b0);
        i_arcp_host_model.close_frame();
      end
      repeat (16) @(posedge clock);
    join
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  initial begin
    apply_reset();
    check("setup_pins", 24'h0, {16'h0, setup_o});
    reg_read(8'h20, 8'h00);
    reg_read(8'h24, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_arcp_host_model.write_frame({8'h40 | 8'(i), vals[i]}, 2, acks);
      repeat (10) @(posedge clock);
      check("ack", 24'h0, {22'h0, acks});
      check("setup_pins", {16'h0, vals[i]}, {16'h0, setup_o});
      reg_read(8'h23, vals[i]);
    end
    check("restarts", 24'h000004, 24'(restarts));
    reg_read(8'h27, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_arcp_host_model.write_frame({others[i], 8'h3C}, 2, acks);
      repeat (10) @(posedge clock);
    end
    check("restarts", 24'h000004, 24'(restarts));
    reg_read(8'h20, 8'hA5);
    convert(24'h812345);
    repeat (3) @(posedge clock);
    check("ready_flag", 24'h1, {23'h0, result_ready_flag});
    check("ready_pin", 24'h1, {23'h0, result_ready_n_oe});
    reg_read(8'h24, 8'h80);
    fetch(24'h812345);
    reg_read(8'h24, 8'h00);
    convert(24'h0F00F1);
    i_arcp_host_model.write_frame(16'h1000, 1, acks);
    fork
      i_arcp_host_model.read_frame(3, w);
      begin
        #60;
        convert(24'h7FFFFE);
      end
    join
    check("in_flight", 24'h0F00F1, w);
    check("ready_flag", 24'h1, {23'h0, result_ready_flag});
    fetch(24'h7FFFFE);
    // A second reset in mid-run must clear a set flag and a written setup
    convert(24'h2468AC);
    @(posedge clock);
    apply_reset();
    check("setup_pins", 24'h0, {16'h0, setup_o});
    check("ready_flag", 24'h0, {23'h0, result_ready_flag});
    reg_read(8'h20, 8'h00);
    reg_read(8'h24, 8'h00);
    print_verdict();
  end
endmodule

/* File: verilog/arcp_link.sv */
// Link-side byte shifter, clocked on falling edges of the serial clock.
// Assumes the addressing logic raises link_frame after the address acknowledge
// and lowers it during any address byte, so the bit count restarts each frame.
`timescale 1ns/1ps
module arcp_link (
  input  wire logic   link_scl,
  input  wire logic   sys_rst,
  input  wire logic   link_frame,
  input  wire logic   link_read,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  arcp_xfer_if.link   xf
);
  typedef struct packed {
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        first;
    logic [7:0]  rx_byte;
    logic        rx_first;
    logic        rx_tog;
    logic        ack;
    logic [1:0]  rd_idx;
    logic [23:0] tx_hold;
    logic [1:0]  tx_len;
    logic        tx_seen;
  } arcp_link_s;

  arcp_link_s st;
  arcp_link_s next_st;
  logic       rst_l;
  logic       tx_tog_l;
  logic [7:0] cur_byte;
  logic       rd_active;

  arcp_sync #(.W(1)) u_rst_sync (.clk(link_scl), .rst(1'b0), .d(sys_rst), .q(rst_l));
  arcp_sync #(.W(1)) u_tx_sync (.clk(link_scl), .rst(rst_l), .d(xf.tx_tog), .q(tx_tog_l));

  // Readback goes out most significant byte first
  always_comb begin
    cur_byte = 8'h00;
    case (st.rd_idx)
      2'h0: cur_byte = (st.tx_len == arcp_pkg::LEN_RESULT) ? st.tx_hold[23:16] : st.tx_hold[7:0];
      2'h1: cur_byte = st.tx_hold[15:8];
      2'h2: cur_byte = st.tx_hold[7:0];
      default: cur_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    // Core word is stable once its toggle has crossed
    if (tx_tog_l != st.tx_seen) begin
      next_st.tx_hold = xf.tx_word;
      next_st.tx_len  = xf.tx_len;
      next_st.tx_seen = tx_tog_l;
    end
    if (!link_frame) begin
      next_st.bit_cnt = 4'h0;
      next_st.first   = 1'b1;
      next_st.ack     = 1'b0;
      next_st.rd_idx  = 2'h0;
    end else begin
      next_st.bit_cnt = (st.bit_cnt == 4'h8) ? 4'h0 : st.bit_cnt + 4'h1;
      if (!link_read && st.bit_cnt < 4'h8) begin
        next_st.shift = {st.shift[6:0], sda_in};
      end
      if (!link_read && st.bit_cnt == 4'h7) begin
        // Byte is latched on its eighth falling edge
        next_st.rx_byte  = {st.shift[6:0], sda_in};
        next_st.rx_first = st.first;
        next_st.rx_tog   = ~st.rx_tog;
        next_st.first    = 1'b0;
        next_st.ack      = 1'b1;
      end
      if (st.bit_cnt == 4'h8) begin
        next_st.ack = 1'b0;
        if (link_read && st.rd_idx != 2'h3) begin
          next_st.rd_idx = st.rd_idx + 2'h1;
        end
      end
    end
    if (rst_l) begin
      next_st = '0;
    end
  end

  always_ff @(negedge link_scl) begin
    st <= next_st;
  end

  // Bytes past the readback length release the line and read as ones
  assign rd_active = link_frame && link_read && st.bit_cnt < 4'h8 && {1'b0, st.rd_idx} < {1'b0, st.tx_len};
  assign sda_out   = rd_active ? cur_byte[3'h7 - st.bit_cnt[2:0]] : 1'b0;
  assign sda_oe    = st.ack || (rd_active && !cur_byte[3'h7 - st.bit_cnt[2:0]]);

  assign xf.rx_byte  = st.rx_byte;
  assign xf.rx_first = st.rx_first;
  assign xf.rx_tog   = st.rx_tog;
endmodule

/* File: verilog/arcp_pkg.sv */
// Shared constants for the converter command port: register map, field layout,
// command opcodes and reset values.
// Assumes the bus addressing and the converter datapath live outside this block.
package arcp_pkg;

  // Register addresses carried in the register-fetch command
  localparam logic       ADDR_SETUP     = 1'h0;
  localparam logic       ADDR_STATUS    = 1'h1;

  // Setup register field positions
  localparam int         PAIR_MSB       = 7;
  localparam int         PAIR_LSB       = 5;
  localparam int         GAIN_BIT       = 4;
  localparam int         RATE_MSB       = 3;
  localparam int         RATE_LSB       = 2;
  localparam int         STYLE_BIT      = 1;
  localparam int         REF_BIT        = 0;

  // Status register ready bit position and register-fetch command address bit position
  localparam int         READY_BIT      = 7;
  localparam int         CMD_ADDR_BIT   = 2;

  // Reset values
  localparam logic [7:0] SETUP_RESET    = 8'h00;
  localparam logic       READY_RESET    = 1'h0;
  // Identification bits; value is arbitrary, kept zero so status resets to zero
  localparam logic [6:0] CHIP_TAG       = 7'h00;

  // Command byte opcodes: mask selects the fixed bits, value is their pattern
  localparam logic [7:0] FETCH_MASK     = 8'hF0;
  localparam logic [7:0] FETCH_VALUE    = 8'h10;
  localparam logic [7:0] REGRD_MASK     = 8'hF8;
  localparam logic [7:0] REGRD_VALUE    = 8'h20;
  localparam logic [7:0] STORE_MASK     = 8'hFC;
  localparam logic [7:0] STORE_VALUE    = 8'h40;

  // Readback lengths in bytes
  localparam logic [1:0] LEN_REGISTER   = 2'h1;
  localparam logic [1:0] LEN_RESULT     = 2'h3;

  typedef enum logic [1:0] {
    CMD_RESULT_FETCH,
    CMD_REGISTER_FETCH,
    CMD_SETUP_STORE,
    CMD_OTHER
  } arcp_cmd_e;

endpackage

/* File: verilog/arcp_sync.sv */
// Two-flop synchroniser for levels and toggles.
// Assumes its input changes no faster than the destination clock can follow.
`timescale 1ns/1ps
module arcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } arcp_sync_s;

  arcp_sync_s st;
  arcp_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.meta   = d;
    next_st.stable = st.meta;
    if (rst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.stable;
endmodule

/* File: verilog/arcp_top.sv */
// Command and register port of a serially attached converter: decodes command
// bytes, holds the setup register, answers register and result readback.
// Assumes an outside addressing block frames the link and that the converter
// delivers results as a one-cycle pulse on the system clock.
//
// How it works
// - Register-fetch command selects register by its address bit for next read.
// - A following read frame returns the selected register's contents.
// - Setup-store command plus one data byte writes the setup register.
// - Each setup write resets the filter and restarts any conversion.
// - Result-fetch command hands out the most recent stored result, not one completing in the same cycle.
// - Ready pin goes low when a new result is available.
// - Status ready flag is set while an unread new result exists.
// - Results finishing mid-transfer only reach readback at the next fetch.
// - Two 8-bit registers: setup at address 0, status at address 1.
// - Reset clears both registers to zero.
// - Power-down keeps every register value.
// - Setup bits 7:5 choose the input pairing.
// - Setup bit 4 chooses gain one or four.
// - Setup bits 3:2 choose output rate 20, 90, 330 or 1000.
// - Setup bit 1 chooses single-shot or continuous conversion.
// - Setup bit 0 chooses internal or external reference.
// - Ready status bit reads one when a new result waits; fetch clears it unless a result lands in the same cycle.
// - Command bytes act only once latched at their eighth falling edge.
// - Result readout is fetch in a write frame, then read frame MSB first.
// - Results are 24-bit two's complement, returned as three bytes.
`timescale 1ns/1ps
module arcp_top #(
  parameter int RESULT_W = 24
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                link_scl,
  input  wire logic                link_frame,
  input  wire logic                link_read,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic                conv_done,
  input  wire logic [RESULT_W-1:0] conv_result,
  output logic      [2:0]          input_pair_select,
  output logic                     gain_x4,
  output logic      [1:0]          rate_code,
  output logic                     conversion_style,
  output logic                     ext_ref_select,
  output logic                     filter_restart,
  output logic                     result_ready_n_out,
  output logic                     result_ready_n_oe,
  output logic                     result_ready_flag
);

  // The readback path and the three-byte sequencing are built for this width
  generate
    if (RESULT_W != 24) begin : g_bad_width
      $error("arcp_top: RESULT_W must be 24");
    end
  endgenerate

  typedef struct packed {
    logic [7:0]  setup;
    logic        ready;
    logic [23:0] latest;
    logic [23:0] tx_word;
    logic [1:0]  tx_len;
    logic        tx_tog;
    logic        rx_seen;
    logic        store_pending;
    logic        restart;
  } arcp_core_s;

  arcp_core_s  st;
  arcp_core_s  next_st;
  arcp_xfer_if xf ();
  logic        rx_tog_c;
  logic        rx_event;
  logic [7:0]  status_value;
  arcp_pkg::arcp_cmd_e cmd;

  // Only fixed opcode bits take part; operand and don't-care bits are masked
  function automatic arcp_pkg::arcp_cmd_e decode_cmd(input logic [7:0] b);
    if ((b & arcp_pkg::FETCH_MASK) == arcp_pkg::FETCH_VALUE) begin
      return arcp_pkg::CMD_RESULT_FETCH;
    end else if ((b & arcp_pkg::REGRD_MASK) == arcp_pkg::REGRD_VALUE) begin
      return arcp_pkg::CMD_REGISTER_FETCH;
    end else if ((b & arcp_pkg::STORE_MASK) == arcp_pkg::STORE_VALUE) begin
      return arcp_pkg::CMD_SETUP_STORE;
    end
    return arcp_pkg::CMD_OTHER;
  endfunction

  arcp_link u_link (
    .link_scl   (link_scl),
    .sys_rst    (sys_rst),
    .link_frame (link_frame),
    .link_read  (link_read),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .xf         (xf.link)
  );

  arcp_sync #(.W(1)) u_rx_sync (
    .clk (clock),
    .rst (sys_rst),
    .d   (xf.rx_tog),
    .q   (rx_tog_c)
  );

  // A toggle change means a freshly latched byte is waiting and stable
  assign rx_event = rx_tog_c != st.rx_seen;
  assign cmd      = decode_cmd(xf.rx_byte);

  // Identification bits are constants, so the host cannot write them
  assign status_value = {st.ready, arcp_pkg::CHIP_TAG};

  always_comb begin
    next_st         = st;
    next_st.restart = 1'b0;

    // New result is held here; readback copy changes only on a fetch
    if (conv_done) begin
      next_st.latest = conv_result;
      next_st.ready  = 1'b1;
    end

    if (rx_event) begin
      next_st.rx_seen = rx_tog_c;
      if (xf.rx_first) begin
        next_st.store_pending = 1'b0;
        case (cmd)
          arcp_pkg::CMD_RESULT_FETCH: begin
            next_st.tx_len = arcp_pkg::LEN_RESULT;
            next_st.tx_tog = ~st.tx_tog;
            if (conv_done) begin
              // A result landing in the same cycle loses to the stored one and stays flagged
              next_st.tx_word = st.latest;
            end else begin
              next_st.tx_word = st.latest;
              next_st.ready   = 1'b0;
            end
          end
          arcp_pkg::CMD_REGISTER_FETCH: begin
            next_st.tx_len = arcp_pkg::LEN_REGISTER;
            next_st.tx_tog = ~st.tx_tog;
            if (xf.rx_byte[arcp_pkg::CMD_ADDR_BIT] == arcp_pkg::ADDR_STATUS) begin
              next_st.tx_word = {16'h0000, status_value};
            end else begin
              next_st.tx_word = {16'h0000, st.setup};
            end
          end
          arcp_pkg::CMD_SETUP_STORE: begin
            next_st.store_pending = 1'b1;
          end
          arcp_pkg::CMD_OTHER: begin
            // Power and restart commands are served outside; registers keep their values
            next_st.store_pending = 1'b0;
          end
          default: begin
            next_st.store_pending = 1'b0;
          end
        endcase
      end else if (st.store_pending) begin
        // Only the byte right after the store command counts; later ones are dropped
        next_st.setup         = xf.rx_byte;
        next_st.restart       = 1'b1;
        next_st.store_pending = 1'b0;
      end
    end

    if (sys_rst) begin
      next_st       = '0;
      next_st.setup = arcp_pkg::SETUP_RESET;
      next_st.ready = arcp_pkg::READY_RESET;
    end
  end

  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign xf.tx_word = st.tx_word;
  assign xf.tx_len  = st.tx_len;
  assign xf.tx_tog  = st.tx_tog;

  // Power state lives outside; nothing here clears on power-down
  assign input_pair_select = st.setup[arcp_pkg::PAIR_MSB:arcp_pkg::PAIR_LSB];
  assign gain_x4           = st.setup[arcp_pkg::GAIN_BIT];
  assign rate_code         = st.setup[arcp_pkg::RATE_MSB:arcp_pkg::RATE_LSB];
  assign conversion_style  = st.setup[arcp_pkg::STYLE_BIT];
  assign ext_ref_select    = st.setup[arcp_pkg::REF_BIT];
  assign filter_restart    = st.restart;
  assign result_ready_flag = st.ready;

  // Open-drain ready pin pulls low while an unread result waits
  assign result_ready_n_out = 1'b0;
  assign result_ready_n_oe  = st.ready;

endmodule

/* File: verilog/arcp_xfer_if.sv */
// Carrier between the link-side shifter and the command core.
// Multi-bit fields are held stable while their toggle travels across the clocks.
`timescale 1ns/1ps
interface arcp_xfer_if;
  logic [7:0]  rx_byte;
  logic        rx_first;
  logic        rx_tog;
  logic [23:0] tx_word;
  logic [1:0]  tx_len;
  logic        tx_tog;

  modport link (output rx_byte, output rx_first, output rx_tog,
                input tx_word, input tx_len, input tx_tog);
  modport core (input rx_byte, input rx_first, input rx_tog,
                output tx_word, output tx_len, output tx_tog);
endinterface
